// >>> common/gpio_params.svh
/*
  constants of the eight-pin gpio port: register offsets, field
  positions and reset values.
  assumes a 32-bit classic wishbone slave with byte addresses.
*/
// Function
// - ordinary pins reset as software inputs
// - debug pins reset with alternate function set
// - every reset restores all pin defaults
// - input pin level captured in data bit
// - output pin driven from data bit
// - data spans 256 words, address masks bits
// - write changes only address-selected data bits
// - read returns zero for unselected bits
// - one combined port interrupt output
// - sense picks edge or level, both-edges
// - polarity picks low/falling or high/rising
// - mask bit one passes interrupt
// - raw shows all, masked shows passed
// - unmasked pin four also triggers converter
// - writing one clears latched interrupt
// - alternate select hands pin to peripheral
// - pad settings held and sent to pads
// - read-only identification registers fixed
// - read gives written outputs, live inputs
// - unconnected bits ignore writes, read zero
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

`define PORT_W 8
`define ADR_W 12

`define OFS_DIR 12'h400
`define OFS_SENSE 12'h404
`define OFS_BOTH 12'h408
`define OFS_POL 12'h40c
`define OFS_MASK 12'h410
`define OFS_RAW 12'h414
`define OFS_MASKED 12'h418
`define OFS_CLEAR 12'h41c
`define OFS_AFSEL 12'h420
`define OFS_DRV_LOW 12'h500
`define OFS_DRV_MID 12'h504
`define OFS_DRV_HIGH 12'h508
`define OFS_OPEN_DRAIN 12'h50c
`define OFS_PULL_UP 12'h510
`define OFS_PULL_DOWN 12'h514
`define OFS_SLEW 12'h518
`define OFS_DIG_EN 12'h51c
`define OFS_ID_FIRST 12'hfd0

`define DATA_MASK_LSB 2
`define DATA_MASK_MSB 9

`define RST_ZERO 8'h00
`define RST_DRV_LOW 8'hff
`define RST_PULL_UP 8'hff
`define RST_DIG_EN 8'hff
`define RST_AFSEL 8'h80

`endif

// >>> common/gpio_pkg.sv
/*
  types of the gpio port: pad settings and the module state.
  assumes gpio_params.svh for the port width.
*/
`include "gpio_params.svh"

package gpio_pkg;

  typedef struct packed {
    logic [`PORT_W-1:0] drive_low_select;
    logic [`PORT_W-1:0] drive_mid_select;
    logic [`PORT_W-1:0] drive_high_select;
    logic [`PORT_W-1:0] open_drain_select;
    logic [`PORT_W-1:0] pull_up_select;
    logic [`PORT_W-1:0] pull_down_select;
    logic [`PORT_W-1:0] slew_rate_select;
    logic [`PORT_W-1:0] digital_input_enable;
  } pad_cfg_type;

  typedef struct packed {
    logic [`PORT_W-1:0] in_meta;
    logic [`PORT_W-1:0] in_sync;
    logic [`PORT_W-1:0] in_prev;
    logic [`PORT_W-1:0] port_data_reg;
    logic [`PORT_W-1:0] pin_direction_reg;
    logic [`PORT_W-1:0] alt_function_select;
    logic [`PORT_W-1:0] irq_sense_select;
    logic [`PORT_W-1:0] irq_both_edges_select;
    logic [`PORT_W-1:0] irq_event_polarity;
    logic [`PORT_W-1:0] irq_mask;
    logic [`PORT_W-1:0] raw_irq_status;
    pad_cfg_type pad;
    logic ack;
    logic [31:0] rdata;
    logic trig;
  } state_type;

endpackage

// >>> hdl/gpio_port.sv
/*
  eight-pin gpio port: data and direction, masked data access,
  edge/level interrupts, converter trigger, pad and id registers.
  assumes a classic wishbone master on core_clk and asynchronous
  pin inputs; the port clock gate lives outside this block.
*/
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_params.svh"

module gpio_port
  import gpio_pkg::*;
#(
  parameter logic [`PORT_W-1:0] AFSEL_RESET = `RST_AFSEL,
  parameter logic [`PORT_W-1:0] PIN_CONNECTED = 8'hff,
  parameter bit TRIG_ENABLE = 1'b1,
  parameter int TRIG_PIN = 4,
  // identification bytes, values arbitrary
  parameter logic [95:0] ID_BYTES = 96'h0102_0304_0506_0708_090a_0b0c
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pins
  input wire logic [`PORT_W-1:0] pin_in,
  output logic [`PORT_W-1:0] pin_out,
  output logic [`PORT_W-1:0] pin_oe,
  // peripheral alternate functions
  input wire logic [`PORT_W-1:0] alt_out,
  input wire logic [`PORT_W-1:0] alt_oe,
  output logic [`PORT_W-1:0] alt_in,
  // pad cells
  output pad_cfg_type pad_cfg,
  // interrupt and converter trigger
  output logic port_irq,
  output logic converter_trigger
);

  state_type st;
  state_type next_st;

  localparam logic [`PORT_W-1:0] CONN = PIN_CONNECTED;

  logic bus_req;
  logic wr_now;
  logic [`PORT_W-1:0] addr_mask;
  logic [`PORT_W-1:0] wbyte;
  logic [`PORT_W-1:0] clr;
  logic [`PORT_W-1:0] rise;
  logic [`PORT_W-1:0] fall;
  logic [`PORT_W-1:0] edge_evt;
  logic [`PORT_W-1:0] level_act;
  logic [`PORT_W-1:0] masked;

  // data window: 256 words below the direction register
  function automatic logic is_data(input logic [`ADR_W-1:0] a);
    return a < `OFS_DIR;
  endfunction

  function automatic logic is_reg(input logic [`ADR_W-1:0] a,
                                  input logic [`ADR_W-1:0] ofs);
    return a[`ADR_W-1:2] == ofs[`ADR_W-1:2];
  endfunction

  function automatic logic [31:0] read_word(
    input logic [`ADR_W-1:0] a,
    input state_type s,
    input logic [`PORT_W-1:0] msk);
    logic [`PORT_W-1:0] v;
    logic [3:0] idx;
    v = '0;
    // id words start one 16-byte block in, so rebase to zero
    idx = a[5:2] - 4'h4;
    if (is_data(a))
      v = s.port_data_reg & a[`DATA_MASK_MSB:`DATA_MASK_LSB];
    else if (is_reg(a, `OFS_DIR))
      v = s.pin_direction_reg;
    else if (is_reg(a, `OFS_SENSE))
      v = s.irq_sense_select;
    else if (is_reg(a, `OFS_BOTH))
      v = s.irq_both_edges_select;
    else if (is_reg(a, `OFS_POL))
      v = s.irq_event_polarity;
    else if (is_reg(a, `OFS_MASK))
      v = s.irq_mask;
    else if (is_reg(a, `OFS_RAW))
      v = s.raw_irq_status;
    else if (is_reg(a, `OFS_MASKED))
      v = msk;
    else if (is_reg(a, `OFS_AFSEL))
      v = s.alt_function_select;
    else if (is_reg(a, `OFS_DRV_LOW))
      v = s.pad.drive_low_select;
    else if (is_reg(a, `OFS_DRV_MID))
      v = s.pad.drive_mid_select;
    else if (is_reg(a, `OFS_DRV_HIGH))
      v = s.pad.drive_high_select;
    else if (is_reg(a, `OFS_OPEN_DRAIN))
      v = s.pad.open_drain_select;
    else if (is_reg(a, `OFS_PULL_UP))
      v = s.pad.pull_up_select;
    else if (is_reg(a, `OFS_PULL_DOWN))
      v = s.pad.pull_down_select;
    else if (is_reg(a, `OFS_SLEW))
      v = s.pad.slew_rate_select;
    else if (is_reg(a, `OFS_DIG_EN))
      v = s.pad.digital_input_enable;
    else if (a >= `OFS_ID_FIRST && idx < 4'hc)
      v = ID_BYTES[8*(4'hb-idx) +: 8];
    // unconnected bits read as zero
    return {24'h0, v & CONN};
  endfunction

  always_comb
  begin
    bus_req = cyc_i && stb_i;
    // write lands on the edge where the master sees ack
    wr_now = bus_req && we_i && st.ack && sel_i[0];
    addr_mask = adr_i[`DATA_MASK_MSB:`DATA_MASK_LSB];
    wbyte = dat_i[`PORT_W-1:0] & CONN;
    clr = (wr_now && is_reg(adr_i, `OFS_CLEAR)) ? wbyte : '0;
    rise = st.in_sync & ~st.in_prev;
    fall = ~st.in_sync & st.in_prev;
    edge_evt = (st.irq_both_edges_select & (rise | fall)) |
               (~st.irq_both_edges_select &
                ((st.irq_event_polarity & rise) |
                 (~st.irq_event_polarity & fall)));
    level_act = (st.irq_event_polarity & st.in_sync) |
                (~st.irq_event_polarity & ~st.in_sync);
    masked = st.raw_irq_status & st.irq_mask;

    next_st = st;
    // first stage read only by the second
    next_st.in_meta = pin_in;
    next_st.in_sync = st.in_meta;
    next_st.in_prev = st.in_sync;
    // input bits keep following the pin
    next_st.port_data_reg =
      (st.port_data_reg & st.pin_direction_reg) |
      (st.in_sync & ~st.pin_direction_reg & CONN);
    // edge: sticky, set wins over clear; level: follows the pin
    next_st.raw_irq_status =
      (st.irq_sense_select & level_act & CONN) |
      (~st.irq_sense_select & CONN &
       ((st.raw_irq_status & ~clr) | edge_evt));
    next_st.trig = TRIG_ENABLE &&
      st.irq_mask[TRIG_PIN] &&
      next_st.raw_irq_status[TRIG_PIN] &&
      !st.raw_irq_status[TRIG_PIN];
    next_st.ack = bus_req && !st.ack;
    next_st.rdata = read_word(adr_i, st, masked);

    if (wr_now)
    begin
      if (is_data(adr_i))
        next_st.port_data_reg =
          (next_st.port_data_reg &
           ~(addr_mask & st.pin_direction_reg & CONN)) |
          (wbyte & addr_mask & st.pin_direction_reg);
      else if (is_reg(adr_i, `OFS_DIR))
        next_st.pin_direction_reg = wbyte;
      else if (is_reg(adr_i, `OFS_SENSE))
        next_st.irq_sense_select = wbyte;
      else if (is_reg(adr_i, `OFS_BOTH))
        next_st.irq_both_edges_select = wbyte;
      else if (is_reg(adr_i, `OFS_POL))
        next_st.irq_event_polarity = wbyte;
      else if (is_reg(adr_i, `OFS_MASK))
        next_st.irq_mask = wbyte;
      else if (is_reg(adr_i, `OFS_AFSEL))
        next_st.alt_function_select = wbyte;
      else if (is_reg(adr_i, `OFS_DRV_LOW))
        next_st.pad.drive_low_select = wbyte;
      else if (is_reg(adr_i, `OFS_DRV_MID))
        next_st.pad.drive_mid_select = wbyte;
      else if (is_reg(adr_i, `OFS_DRV_HIGH))
        next_st.pad.drive_high_select = wbyte;
      else if (is_reg(adr_i, `OFS_OPEN_DRAIN))
        next_st.pad.open_drain_select = wbyte;
      else if (is_reg(adr_i, `OFS_PULL_UP))
        next_st.pad.pull_up_select = wbyte;
      else if (is_reg(adr_i, `OFS_PULL_DOWN))
        next_st.pad.pull_down_select = wbyte;
      else if (is_reg(adr_i, `OFS_SLEW))
        next_st.pad.slew_rate_select = wbyte;
      else if (is_reg(adr_i, `OFS_DIG_EN))
        next_st.pad.digital_input_enable = wbyte;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.alt_function_select <= AFSEL_RESET;
      st.pad.drive_low_select <= `RST_DRV_LOW;
      st.pad.pull_up_select <= `RST_PULL_UP;
      st.pad.digital_input_enable <= `RST_DIG_EN;
    end
    else
      st <= next_st;
  end

  // pin muxing; open drain only ever pulls low
  always_comb
  begin
    for (int i = 0; i < `PORT_W; i++)
    begin
      if (st.alt_function_select[i])
      begin
        pin_out[i] = st.pad.open_drain_select[i] ? 1'b0 : alt_out[i];
        pin_oe[i] = alt_oe[i] &&
          (!st.pad.open_drain_select[i] || !alt_out[i]);
      end
      else
      begin
        pin_out[i] = st.pad.open_drain_select[i] ? 1'b0 :
                     st.port_data_reg[i];
        pin_oe[i] = st.pin_direction_reg[i] && CONN[i] &&
          (!st.pad.open_drain_select[i] ||
           !st.port_data_reg[i]);
      end
    end
  end

  assign alt_in = st.in_sync;
  assign pad_cfg = st.pad;
  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign port_irq = |masked;
  assign converter_trigger = st.trig;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_data_write;
    cyc_i && stb_i && we_i && ack_o && sel_i[0] && is_data(adr_i);
  endsequence

  sequence s_data_read;
    cyc_i && stb_i && !we_i && !ack_o && is_data(adr_i);
  endsequence

  sequence s_clear_write;
    cyc_i && stb_i && we_i && ack_o && sel_i[0] &&
    is_reg(adr_i, `OFS_CLEAR);
  endsequence

  a_reset_dir_clear: assert property (
    $rose(rst_n) |-> st.pin_direction_reg == '0)
    else $error("direction not clear after reset");

  a_reset_debug_af: assert property (
    $rose(rst_n) |-> st.alt_function_select == AFSEL_RESET)
    else $error("alternate select wrong after reset");

  a_reset_pad_default: assert property (
    $rose(rst_n) |-> st.pad.pull_up_select == `RST_PULL_UP &&
      st.irq_mask == '0 && st.port_data_reg == '0)
    else $error("pad or data not at default after reset");

  a_input_capture: assert property (
    ##1 ((st.port_data_reg ^ $past(st.in_sync)) &
         ~$past(st.pin_direction_reg) & CONN) == '0)
    else $error("input data bit does not follow pin");

  a_output_drive: assert property (
    s_data_write ##1 st.pin_direction_reg[0] &&
      !st.alt_function_select[0] && !st.pad.open_drain_select[0]
    |-> pin_oe[0] && pin_out[0] == st.port_data_reg[0])
    else $error("output pin not driven from data");

  a_write_masked: assert property (
    s_data_write |=>
      ((st.port_data_reg ^ $past(st.port_data_reg)) &
       $past(st.pin_direction_reg) &
       ~$past(adr_i[`DATA_MASK_MSB:`DATA_MASK_LSB])) == '0 &&
      ((st.port_data_reg ^ $past(dat_i[`PORT_W-1:0])) &
       $past(st.pin_direction_reg & CONN &
             adr_i[`DATA_MASK_MSB:`DATA_MASK_LSB])) == '0)
    else $error("data write touched a masked bit");

  a_read_masked: assert property (
    s_data_read ##1 ack_o |->
      (dat_o[`PORT_W-1:0] &
       ~$past(adr_i[`DATA_MASK_MSB:`DATA_MASK_LSB])) == '0 &&
      dat_o[31:`PORT_W] == '0)
    else $error("masked data bit read nonzero");

  a_irq_combined: assert property (
    port_irq == |(st.raw_irq_status & st.irq_mask))
    else $error("port interrupt not or of masked status");

  a_edge_sets: assert property (
    ##1 ($past(rise[0]) && !$past(st.irq_sense_select[0]) &&
         $past(st.irq_event_polarity[0]) && CONN[0])
    |-> st.raw_irq_status[0])
    else $error("rising edge did not set raw status");

  a_clear_w1c: assert property (
    s_clear_write and (dat_i[0] && !edge_evt[0] &&
      !st.irq_sense_select[0]) |=> !st.raw_irq_status[0])
    else $error("write one did not clear status");

  a_trigger_pulse: assert property (
    converter_trigger |-> TRIG_ENABLE &&
      st.raw_irq_status[TRIG_PIN] && $past(st.irq_mask[TRIG_PIN]) ##1
      !converter_trigger)
    else $error("converter trigger without unmasked event");

  a_ack_single: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle answer");

endmodule // gpio_port

`default_nettype wire

// >>> test/gpio_far_side.sv
/*
  far side of the gpio port: the pad wire and the peripherals.
  assumes the bench sets the outside level and the peripheral drive.
*/
`timescale 1ns/1ps
`default_nettype none

module gpio_far_side
(
  // bench control
  input wire logic [7:0] ext_level,
  input wire logic [7:0] per_val,
  input wire logic [7:0] per_en,
  // port pins
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_in,
  output logic [7:0] alt_out,
  output logic [7:0] alt_oe
);
  // a driven pin reads its own drive, a released one the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
  assign alt_out = per_val;
  assign alt_oe = per_en;
endmodule // gpio_far_side

`default_nettype wire

// >>> test/gpio_port_tb.sv
/*
  self-checking bench of the gpio port over classic wishbone.
  assumes gpio_far_side for the pins; pin 6 is built unconnected.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpio_params.svh"

module gpio_port_tb
  import gpio_pkg::*;
;
  logic core_clk, rst_n, cyc_i, stb_i, we_i, port_irq, converter_trigger;
  logic [11:0] adr_i;
  logic [31:0] dat_i, dat_o, q;
  logic [3:0] sel_i;
  logic ack_o;
  logic [7:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in;
  logic [7:0] ext_level, per_val, per_en;
  pad_cfg_type pad_cfg;
  int miscompares, samples_checked, cycles, trig_cnt, t0;

  gpio_port #(.PIN_CONNECTED(8'hbf)) u_dut (.core_clk(core_clk),
    .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o),
    .ack_o(ack_o), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
    .pad_cfg(pad_cfg), .port_irq(port_irq),
    .converter_trigger(converter_trigger));

  gpio_far_side u_far (.ext_level(ext_level), .per_val(per_val),
    .per_en(per_en), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in), .alt_out(alt_out), .alt_oe(alt_oe));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // a hang anywhere ends here, well past the expected run length
  always @(posedge core_clk)
  begin
    cycles++;
    if (converter_trigger === 1'b1)
      trig_cnt++;
    if (cycles == 4000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // no fixed latency assumed: wait on ack under a bound
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack_o !== 1'b1 && n < 16);
    q = dat_o;
    chk("ack", 32'h1, {31'h0, ack_o});
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rc(input string n, input logic [11:0] a,
                    input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, q);
  endtask

  // long enough for two sync flops and the status flop
  task automatic pins(input logic [7:0] v);
    @(posedge core_clk);
    ext_level <= v;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  logic [11:0] ra [6] = '{`OFS_DIR, `OFS_AFSEL, `OFS_DRV_LOW,
                          `OFS_PULL_UP, `OFS_DIG_EN, `OFS_SLEW};
  // register reads hide the unconnected pin 6
  logic [7:0] rv [6] = '{8'h00, 8'h80, 8'hbf, 8'hbf, 8'hbf, 8'h00};

  initial
  begin
    rst_n = 1'b0;
    {cyc_i, stb_i, we_i} = 3'b000;
    adr_i = 12'h000;
    dat_i = 32'h0;
    sel_i = 4'h1;
    ext_level = 8'he5;
    {per_val, per_en} = 16'h0000;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 6; i++)
      rc("reset reg", ra[i], rv[i]);
    chk("pad hi", 32'hff00_0000, pad_cfg[63:32]);
    chk("pad lo", 32'hff00_00ff, pad_cfg[31:0]);
    chk("irq", 32'h0, {31'h0, port_irq});
    wr(`OFS_SLEW, 8'h3c);
    @(negedge core_clk);
    chk("slew", 32'h3c, {24'h0, pad_cfg.slew_rate_select});
    pins(8'he5);
    rc("data all", 12'h3fc, 8'ha5);
    rc("data mask", 12'h0c4, 8'h21);
    wr(`OFS_DIR, 8'h0f);
    wr(12'h098, 8'heb);
    @(negedge core_clk);
    chk("oe", 32'h0f, {24'h0, pin_oe});
    // bits 0 and 3 keep the pin level held while they were inputs
    chk("out", 32'h3, {28'h0, pin_out[3:0]});
    rc("data mixed", 12'h3fc, 8'ha3);
    rc("data mixed mask", 12'h0c4, 8'h21);
    wr(`OFS_AFSEL, 8'h80);
    @(posedge core_clk);
    per_val <= 8'h80;
    per_en <= 8'h80;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk("alt oe", 32'h8f, {24'h0, pin_oe});
    chk("alt out", 32'h1, {31'h0, pin_out[7]});
    chk("alt in", 32'h1, {31'h0, alt_in[7]});
    wr(`OFS_AFSEL, 8'h00);
    @(negedge core_clk);
    chk("gpio oe", 32'h0f, {24'h0, pin_oe});
    wr(`OFS_DIR, 8'h00);
    pins(8'he4);
    wr(`OFS_POL, 8'h01);
    wr(`OFS_CLEAR, 8'hff);
    wr(`OFS_MASK, 8'h01);
    rc("raw idle", `OFS_RAW, 8'h00);
    pins(8'he5);
    rc("raw rise", `OFS_RAW, 8'h01);
    rc("masked rise", `OFS_MASKED, 8'h01);
    chk("irq rise", 32'h1, {31'h0, port_irq});
    wr(`OFS_CLEAR, 8'h00);
    rc("raw keep", `OFS_RAW, 8'h01);
    wr(`OFS_CLEAR, 8'h01);
    rc("raw cleared", `OFS_RAW, 8'h00);
    chk("irq cleared", 32'h0, {31'h0, port_irq});
    pins(8'he4);
    rc("raw fall", `OFS_RAW, 8'h00);
    wr(`OFS_MASK, 8'h00);
    wr(`OFS_BOTH, 8'h01);
    pins(8'he5);
    wr(`OFS_CLEAR, 8'h01);
    pins(8'he4);
    rc("raw both", `OFS_RAW, 8'h01);
    rc("masked off", `OFS_MASKED, 8'h00);
    chk("irq off", 32'h0, {31'h0, port_irq});
    wr(`OFS_BOTH, 8'h00);
    wr(`OFS_POL, 8'h00);
    wr(`OFS_SENSE, 8'h01);
    wr(`OFS_CLEAR, 8'h01);
    rc("raw level", `OFS_RAW, 8'h01);
    wr(`OFS_MASK, 8'h01);
    @(negedge core_clk);
    chk("irq level", 32'h1, {31'h0, port_irq});
    pins(8'he5);
    rc("raw level gone", `OFS_RAW, 8'h00);
    wr(`OFS_MASK, 8'h00);
    wr(`OFS_SENSE, 8'h00);
    wr(`OFS_POL, 8'h10);
    wr(`OFS_CLEAR, 8'hff);
    wr(`OFS_MASK, 8'h10);
    t0 = trig_cnt;
    pins(8'hf5);
    repeat (4) @(posedge core_clk);
    chk("trigger", 32'h1, trig_cnt - t0);
    rc("raw pin4", `OFS_RAW, 8'h10);
    wb(1'b0, `OFS_ID_FIRST, 8'h00);
    chk("id first", 32'h01, q);
    wr(`OFS_ID_FIRST, 8'hfe);
    rc("id", `OFS_ID_FIRST, 8'h01);
    rc("id last", 12'hffc, 8'h0c);
    wr(12'h600, 8'h5a);
    rc("unmapped", 12'h600, 8'h00);
    wr(`OFS_OPEN_DRAIN, 8'h01);
    wr(`OFS_DIR, 8'h01);
    wr(12'h004, 8'h00);
    @(negedge core_clk);
    chk("od low", 32'h1, {31'h0, pin_oe[0]});
    chk("od out", 32'h0, {31'h0, pin_out[0]});
    wr(12'h004, 8'h01);
    @(negedge core_clk);
    chk("od high", 32'h0, {31'h0, pin_oe[0]});
    wr(`OFS_DIR, 8'hff);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rc("dir rerst", `OFS_DIR, 8'h00);
    rc("afsel rerst", `OFS_AFSEL, 8'h80);
    end_of_test();
  end
endmodule // gpio_port_tb

`default_nettype wire
